// ===== hdl/swd_core.sv
// Memory-mapped system watchdog: control and feed registers, counter, reset out.
// Assumes a single-cycle strobe register port on mclk; sys_rst_q feeds board reset.
// Assumes the board reset raised by sys_rst_q also reaches arst_n; the pulse
// length is only a floor for boards that stretch it through slower reset logic.
//
// Contract
// - Counter reaching selected period asserts full system reset.
// - Code 0 off, 1..3 = 250ms..1s, 4 reserved, 5..7 = 2s..8s.
// - Counting starts as soon as a nonzero code enables the watchdog.
// - A valid feed clears the counter at any time while enabled; the code does not clear it during the reset pulse.
// - Feed means writing hex 05 to the feed register.
// - Control write accepted only within 30 us after a feed.
// - Control write without preceding feed leaves code unchanged.
//
// Our own choice: strobed register access.
`include "swd_defs.svh"
module swd_core #(
   parameter int unsigned BASE_CYC = `SWD_BASE_CYC,
   parameter int unsigned WIN_CYC = `SWD_WIN_CYC,
   parameter int unsigned RST_CYC = `SWD_RST_CYC
) (
   input wire logic mclk, // Clock, 25 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic [31:0] addr, // Register byte address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata_q, // Read data, cycle after rd
   output swd_pkg::swd_code_t code_q, // Stored timeout code
   output logic sys_rst_q // System reset request, active high
);
   import swd_pkg::*;
   // Period in 250 ms units for each code; reserved and off give zero
   // One shared divider plus a small unit count keeps the counter narrow even for 8 s
   function automatic logic [5:0] units_of(input swd_code_t c);
      case (c)
         SWD_T250: units_of = 6'h01;
         SWD_T500: units_of = 6'h02;
         SWD_T1S: units_of = 6'h04;
         SWD_T2S: units_of = 6'h08;
         SWD_T4S: units_of = 6'h10;
         SWD_T8S: units_of = 6'h20;
         default: units_of = 6'h00;
      endcase
   endfunction
   // Decoded strobes and timer state
   logic feed_ok, ctrl_wr, win_open, tick, enabled, fire_now;
   logic [31:0] win_q;
   logic [5:0] units_q;
   logic [7:0] rst_q;
   swd_state_t st_q;
   assign feed_ok = wr && addr == `SWD_FEED_ADDR && wdata == `SWD_FEED_KEY;
   assign ctrl_wr = wr && addr == `SWD_CTRL_ADDR;
   assign win_open = win_q != 32'h0;
   // Reserved code counts as disabled so it can never fire
   assign enabled = units_of(code_q) != 6'h00;
   // Timeout on this edge; a feed in the same cycle wins and keeps the system up
   assign fire_now = st_q == SWD_ST_RUN && enabled && tick && !feed_ok
      && units_q + 6'h01 >= units_of(code_q);
   // ==========================================
   // Feed window: reloads on every valid feed
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         win_q <= 32'h0;
      end else if (feed_ok) begin
         win_q <= 32'(WIN_CYC);
      end else if (win_open) begin
         win_q <= win_q - 32'h1;
      end
   end
   // ==========================================
   // Control register; a write outside the window is dropped
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         code_q <= swd_code_t'(`SWD_CODE_RESET);
      end else if (ctrl_wr && win_open) begin
         code_q <= swd_code_t'(wdata[2:0]);
      end
   end
   // ==========================================
   // Unit divider, restarted by a feed or while disabled
   swd_tick #(.BASE_CYC(BASE_CYC)) i_swd_tick (
      .mclk(mclk),
      .arst_n(arst_n),
      .clr(feed_ok || !enabled),
      .tick(tick)
   );
   // ==========================================
   // Timeout state machine
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= SWD_ST_IDLE;
         units_q <= 6'h0;
         rst_q <= 8'h0;
      end else begin
         case (st_q)
            SWD_ST_IDLE: begin
               // Parked: the divider is held clear until a code other than off or reserved arrives
               units_q <= 6'h0;
               if (enabled) st_q <= SWD_ST_RUN;
            end
            SWD_ST_RUN: begin
               // A feed outranks a tick that lands in the same cycle
               if (!enabled) begin
                  st_q <= SWD_ST_IDLE;
               end else if (feed_ok) begin
                  units_q <= 6'h0;
               end else if (tick) begin
                  if (units_q + 6'h1 >= units_of(code_q)) begin
                     st_q <= SWD_ST_FIRE;
                     rst_q <= 8'(RST_CYC);
                  end else begin
                     units_q <= units_q + 6'h1;
                  end
               end
            end
            SWD_ST_FIRE: begin
               // Holds reset a fixed time; the board reset normally clears us too
               if (rst_q == 8'h1) begin
                  st_q <= SWD_ST_IDLE;
                  units_q <= 6'h0;
               end
               rst_q <= rst_q - 8'h1;
            end
            default: st_q <= SWD_ST_IDLE;
         endcase
      end
   end
   // ==========================================
   // Reset request: raised on the firing edge itself, so no cycle is lost to the FSM
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) sys_rst_q <= 1'b0;
      else sys_rst_q <= fire_now || (st_q == SWD_ST_FIRE && rst_q > 8'h01);
   end
   // ==========================================
   // Read port: control readable, feed reads zero
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rdata_q <= 8'h0;
      else if (rd && addr == `SWD_CTRL_ADDR) rdata_q <= {5'h0, code_q};
      else rdata_q <= 8'h0;
   end
   // ==========================================
   // Checks
   AST_NO_FEED_NO_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      (ctrl_wr && !win_open) |=> $stable(code_q)) else $error("control loaded without feed");
   AST_FEED_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      (ctrl_wr && win_open) |=> code_q == swd_code_t'($past(wdata[2:0]))) else $error("control not loaded");
   AST_WIN_RELOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      feed_ok |=> win_q == 32'(WIN_CYC)) else $error("feed did not open window");
   AST_BAD_FEED: assert property (@(posedge mclk) disable iff (!arst_n)
      (wr && addr == `SWD_FEED_ADDR && wdata != `SWD_FEED_KEY && !win_open) |=> !win_open)
      else $error("bad feed opened window");
   AST_FEED_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
      (feed_ok && st_q == SWD_ST_RUN && enabled) |=> units_q == 6'h0 && !sys_rst_q)
      else $error("feed did not clear counter");
   AST_OFF_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
      (code_q == SWD_OFF && st_q == SWD_ST_IDLE) |=> !sys_rst_q) else $error("reset while disabled");
   AST_START: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_IDLE && enabled) |=> st_q == SWD_ST_RUN) else $error("count did not start");
   AST_FIRE: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_RUN && enabled && tick && !feed_ok && units_q + 6'h1 >= units_of(code_q))
      |=> sys_rst_q && st_q == SWD_ST_FIRE) else $error("timeout did not reset");
   // Shortest code fires on its very first unit
   AST_DECODE: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_RUN && enabled && tick && !feed_ok && units_q == 6'h00 && code_q == SWD_T250)
      |=> sys_rst_q) else $error("bad period decode");
   // Longest code must not fire one unit early
   AST_DECODE_8S: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_RUN && tick && units_q == 6'h1e && code_q == SWD_T8S) |=> !sys_rst_q)
      else $error("long period fired early");
   // Reserved code never raises reset
   AST_RSVD_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
      (code_q == SWD_RSVD && st_q != SWD_ST_FIRE) |=> !sys_rst_q)
      else $error("reserved code fired");
   // Disabling mid-count parks the timer
   AST_OFF_STOP: assert property (@(posedge mclk) disable iff (!arst_n)
      (!enabled && st_q == SWD_ST_RUN) |=> st_q == SWD_ST_IDLE)
      else $error("timer kept running while off");
   // Wrong key leaves the unit count alone
   AST_BAD_FEED_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      (wr && addr == `SWD_FEED_ADDR && wdata != `SWD_FEED_KEY && st_q == SWD_ST_RUN && enabled && !tick)
      |=> units_q == $past(units_q)) else $error("bad feed moved counter");
   // Divider is restarted by a feed or while off
   AST_TICK_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
      (feed_ok || !enabled) |=> !tick) else $error("divider not restarted");
   // ==========================================
   // Checks on the window
   // Window shrinks by one each cycle after a feed
   AST_WIN_COUNT: assert property (@(posedge mclk) disable iff (!arst_n)
      (win_open && !feed_ok) |=> win_q == $past(win_q) - 32'h1) else $error("window count wrong");
   // A closed window stays closed without a feed
   AST_WIN_SHUT: assert property (@(posedge mclk) disable iff (!arst_n)
      (!win_open && !feed_ok) |=> !win_open) else $error("window opened without feed");
   // ==========================================
   // Checks on the reset pulse and read port
   // Reset can only rise on a unit tick
   AST_NO_EARLY: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_RUN && !tick) |=> !sys_rst_q) else $error("reset between ticks");
   // Firing loads the full pulse length
   AST_RST_LOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      fire_now |=> st_q == SWD_ST_FIRE && rst_q == 8'(RST_CYC)) else $error("pulse not loaded");
   // Pulse holds while the length count runs
   AST_RST_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_FIRE && rst_q > 8'h01) |=> sys_rst_q) else $error("reset pulse dropped");
   // Pulse ends and the timer parks when the count runs out
   AST_RST_END: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_q == SWD_ST_FIRE && rst_q == 8'h01) |=> !sys_rst_q && st_q == SWD_ST_IDLE)
      else $error("reset pulse too long");
   // Reset is only ever high while the timer is in the firing state
   AST_ONLY_FIRE: assert property (@(posedge mclk) disable iff (!arst_n)
      sys_rst_q |-> st_q == SWD_ST_FIRE) else $error("reset outside firing state");
   // Control read returns the stored code in the following cycle
   AST_RD_DATA: assert property (@(posedge mclk) disable iff (!arst_n)
      (rd && addr == `SWD_CTRL_ADDR) |=> rdata_q == {5'h0, $past(code_q)}) else $error("bad read data");
   // Read data is zero outside a control read, feed register included
   AST_RD_IDLE: assert property (@(posedge mclk) disable iff (!arst_n)
      !(rd && addr == `SWD_CTRL_ADDR) |=> rdata_q == 8'h00) else $error("stray read data");
endmodule // swd_core

// ===== hdl/swd_defs.svh
// Constants for the system watchdog: register offsets, codes and timing counts.
// Assumes a 25 MHz clock on mclk; included by bare name.
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH
// ==========================================
// Register map
`define SWD_CTRL_ADDR 32'h2380_0000
`define SWD_FEED_ADDR 32'h23c0_0000
`define SWD_FEED_KEY 8'h05
`define SWD_CODE_RESET 3'h0
// ==========================================
// Timing
`define SWD_CLK_HZ 25000000
`define SWD_WIN_US 30
`define SWD_WIN_CYC ((`SWD_WIN_US * `SWD_CLK_HZ) / 1000000)
`define SWD_BASE_MS 250
`define SWD_BASE_CYC ((`SWD_BASE_MS * `SWD_CLK_HZ) / 1000)
`define SWD_RST_CYC 16
`endif

// ===== hdl/swd_pkg.sv
// Types shared by the system watchdog files.
// Assumes nothing beyond a SystemVerilog compiler.
package swd_pkg;
   // ==========================================
   // Timeout selection code
   typedef enum logic [2:0] {
      SWD_OFF = 3'b000, SWD_T250 = 3'b001, SWD_T500 = 3'b010, SWD_T1S = 3'b011,
      SWD_RSVD = 3'b100, SWD_T2S = 3'b101, SWD_T4S = 3'b110, SWD_T8S = 3'b111
   } swd_code_t;
   typedef enum logic [1:0] {
      SWD_ST_IDLE = 2'b00, SWD_ST_RUN = 2'b01, SWD_ST_FIRE = 2'b10
   } swd_state_t;
endpackage

// ===== hdl/swd_tick.sv
// Divider making a one-cycle tick every BASE_CYC clocks (the 250 ms unit).
// Assumes the same clock and reset as the watchdog core; clr restarts the phase.
module swd_tick #(
   parameter int unsigned BASE_CYC = 6250000
) (
   input wire logic mclk, // Clock
   input wire logic arst_n, // Async reset, active low
   input wire logic clr, // Restart the division
   output logic tick // One-cycle pulse per unit
);
   logic [31:0] cnt_q;
   // ==========================================
   // Divider; restart on feed so each period is a whole number of units
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else if (clr) begin
         cnt_q <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_q == 32'(BASE_CYC - 1)) begin
         cnt_q <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // swd_tick

// ===== tb/swd_core_test.sv
// Self-checking bench for the system watchdog core: codes, window, feeds, reset.
// Assumes the strobe register port and shortened unit and window counts.
`include "swd_defs.svh"
module swd_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   import swd_pkg::*;
   localparam int unsigned BASE = 20;
   localparam int unsigned WIN = 10;
   localparam int LIM = 800;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [7:0] wdata = 8'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata_q;
   swd_code_t code_q;
   logic sys_rst_q;
   int errors = 0;
   int n_checks = 0;
   int units [8] = '{0, 1, 2, 4, 0, 8, 16, 32};
   int t;
   int h;
   // ==========================================
   // Clock and device; short counts keep each timeout within a few hundred cycles
   always #20 mclk = ~mclk;
   swd_core #(.BASE_CYC(BASE), .WIN_CYC(WIN), .RST_CYC(`SWD_RST_CYC)) i_swd_core (.mclk(mclk), .arst_n(arst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .code_q(code_q),
      .sys_rst_q(sys_rst_q));
   // ==========================================
   // Helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One-cycle strobes, changed just after the edge
   task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1; // Let the written register settle before the caller looks
   endtask
   task automatic rd_code(input logic [2:0] exp);
      @(posedge mclk);
      addr <= `SWD_CTRL_ADDR;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check({24'h0, rdata_q}, {29'h0, exp});
   endtask
   // Feed with a given key, wait, then write the control register
   task automatic ctrl(input logic [7:0] key, input logic [7:0] c, input int gap);
      reg_wr(`SWD_FEED_ADDR, key);
      repeat (gap) @(posedge mclk);
      reg_wr(`SWD_CTRL_ADDR, c);
   endtask
   // Cycles until the reset request (lim if none), then how long it stays high
   task automatic measure(input int lim, output int tt, output int hh);
      tt = 0;
      hh = 0;
      while (sys_rst_q !== 1'b1 && tt < lim) begin
         @(posedge mclk);
         #1 tt++;
      end
      while (sys_rst_q === 1'b1 && hh < 40) begin
         @(posedge mclk);
         #1 hh++;
      end
   endtask
   task automatic do_reset;
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      // Every code: stored, then timed from the enabling write
      for (int c = 0; c < 8; c++) begin
         check({29'h0, code_q}, 32'h0);
         ctrl(`SWD_FEED_KEY, c[7:0], 0);
         check({29'h0, code_q}, c);
         measure(LIM, t, h);
         if (units[c] == 0) begin
            check(t, LIM);
         end else begin
            check(t >= units[c] * BASE - 1 && t <= units[c] * BASE + 4, 1);
            check(h, `SWD_RST_CYC);
         end
         do_reset;
      end
      $display("test codes done");
      // Window edges: a write on the last open cycle loads, refused writes leave the code alone
      ctrl(`SWD_FEED_KEY, 8'h03, WIN - 2);
      check({29'h0, code_q}, 32'h3);
      repeat (WIN) @(posedge mclk);
      reg_wr(`SWD_CTRL_ADDR, 8'h01);
      check({29'h0, code_q}, 32'h3);
      ctrl(8'h06, 8'h01, 0);
      check({29'h0, code_q}, 32'h3);
      ctrl(`SWD_FEED_KEY, 8'h02, WIN - 1);
      check({29'h0, code_q}, 32'h3);
      rd_code(3'h3);
      ctrl(`SWD_FEED_KEY, 8'hfd, 0);
      check({29'h0, code_q}, 32'h5);
      $display("test window done");
      // Regular feeds hold the reset off; the last one restarts the full period
      for (int k = 0; k < 5; k++) begin
         measure(100, t, h);
         check(t, 100);
         reg_wr(`SWD_FEED_ADDR, `SWD_FEED_KEY);
      end
      // A wrong key right after the last feed must not restart the period
      reg_wr(`SWD_FEED_ADDR, 8'h50);
      measure(LIM, t, h);
      check(t >= 8 * BASE - 3 && t <= 8 * BASE, 1);
      check(h, `SWD_RST_CYC);
      $display("test feed done");
      finish_test;
   end
endmodule // swd_core_test
